// file: scl_consts.svh
// Constants of the startup configuration loader: offsets, layouts, reset values.
// Assumes inclusion by the loader package and its modules only.
`ifndef SCL_CONSTS_SVH
`define SCL_CONSTS_SVH

// ----------------------------------------------------------------
// Configuration store geometry
// ----------------------------------------------------------------
`define SCL_SEG_COUNT       5'h14
`define SCL_FILE_MAX        5'h0F
`define SCL_SEL_MAX         4'hE
`define SCL_SEG_W           5
`define SCL_WORD_W          2
`define SCL_STORE_AW        7
`define SCL_DATA_W          8
`define SCL_RAIL_COUNT      5

// ----------------------------------------------------------------
// Word layout inside one segment
// ----------------------------------------------------------------
`define SCL_WORD_I2C        2'h0
`define SCL_WORD_PMB        2'h1
`define SCL_WORD_CTRL       2'h2
`define SCL_WORD_SWEN       2'h3
`define SCL_WORD_LAST       2'h3
`define SCL_HDR_SEG         5'h00
`define SCL_HDR_WORD        2'h2
`define SCL_HDR_CNT_LSB     4
`define SCL_HDR_CNT_MSB     7

// ----------------------------------------------------------------
// Register selects on the host register port
// ----------------------------------------------------------------
`define SCL_REG_I2C         3'h0
`define SCL_REG_PMB         3'h1
`define SCL_REG_CTRL        3'h2
`define SCL_REG_SWEN        3'h3
`define SCL_REG_STATUS      3'h4
`define SCL_REG_SEL         3'h5

// ----------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------
`define SCL_CTRL_EXT_OFS    0
`define SCL_CTRL_SW_OVR     1
`define SCL_CTRL_CNT_LSB    4
`define SCL_CTRL_CNT_MSB    7
`define SCL_I2C_RESET       7'h10
`define SCL_PMB_RESET       7'h40
`define SCL_CTRL_RESET      8'h00
`define SCL_SWEN_RESET      5'h00

`endif

// file: scl_loader.sv
// Startup configuration loader: power-on gate, store load, addressing, rail enables.
// Assumes a synchronous config store read port with one cycle of latency and
// resistor codes already digitised by the analog front end.
`timescale 1ns/1ns
`default_nettype none
`include "scl_consts.svh"

module scl_loader
  import scl_pkg::*;
(
  input  wire logic                         CORE_CLK,
  input  wire logic                         SYS_RST,
  input  wire logic                         SUPPLY_OK,
  input  wire logic                         CORE_RAIL_OK,
  input  wire logic                         OSC_STABLE,
  input  wire logic [3:0]                   SEG_SEL_CODE,
  input  wire logic [3:0]                   ADDR_OFS_CODE,
  input  wire logic [`SCL_RAIL_COUNT-1:0]   RAIL_EN_PIN,
  input  wire logic [`SCL_RAIL_COUNT-1:0]   VIN_UV_OK,
  output var  logic [`SCL_STORE_AW-1:0]     CFG_RD_ADDR,
  input  wire logic [`SCL_DATA_W-1:0]       CFG_RD_DATA,
  input  wire logic [19:0]                  CFG_SEG_WRITTEN,
  input  wire logic                         PROG_REQ,
  input  wire logic [`SCL_SEG_W-1:0]        PROG_SEG,
  input  wire logic [`SCL_WORD_W-1:0]       PROG_WORD,
  input  wire logic [`SCL_DATA_W-1:0]       PROG_DATA,
  output var  logic                         CFG_WR_EN,
  output var  logic [`SCL_STORE_AW-1:0]     CFG_WR_ADDR,
  output var  logic [`SCL_DATA_W-1:0]       CFG_WR_DATA,
  output var  logic                         PROG_REFUSED,
  input  wire logic                         HOST_WR_EN,
  input  wire logic [2:0]                   HOST_SEL,
  input  wire logic [`SCL_DATA_W-1:0]       HOST_WR_DATA,
  output var  logic [`SCL_DATA_W-1:0]       HOST_RD_DATA,
  output var  logic                         POR_DONE,
  output var  logic                         LOAD_DONE,
  output var  logic [6:0]                   I2C_ADDR,
  output var  logic                         I2C_ENABLE,
  output var  logic [6:0]                   PMB_ADDR,
  output var  logic                         PMB_ENABLE,
  output var  logic [`SCL_RAIL_COUNT-1:0]   RAIL_CONV_EN
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]                 power_good;
  logic [3:0]                 sel_code;
  logic [3:0]                 ofs_code;
  logic [`SCL_RAIL_COUNT-1:0] en_pin;
  logic [`SCL_RAIL_COUNT-1:0] uv_ok;

  scl_sync #(.WIDTH(3)) u_sync_power
  (
    .clk      (CORE_CLK),
    .rst      (SYS_RST),
    .async_in ({SUPPLY_OK, CORE_RAIL_OK, OSC_STABLE}),
    .sync_out (power_good)
  );

  scl_sync #(.WIDTH(8)) u_sync_codes
  (
    .clk      (CORE_CLK),
    .rst      (SYS_RST),
    .async_in ({SEG_SEL_CODE, ADDR_OFS_CODE}),
    .sync_out ({sel_code, ofs_code})
  );

  scl_sync #(.WIDTH(2*`SCL_RAIL_COUNT)) u_sync_rails
  (
    .clk      (CORE_CLK),
    .rst      (SYS_RST),
    .async_in ({RAIL_EN_PIN, VIN_UV_OK}),
    .sync_out ({en_pin, uv_ok})
  );

  // ----------------------------------------------------------------
  // Internal power-on reset
  // ----------------------------------------------------------------
  logic por_released;

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      por_released <= 1'b0;
    else if (!(&power_good))
      por_released <= 1'b0;
    else
      por_released <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Load sequence
  // ----------------------------------------------------------------
  scl_state_type             state;
  logic [`SCL_WORD_W-1:0]    word_idx;
  logic [`SCL_SEG_W-1:0]     load_seg;
  logic [3:0]                sel_held;
  logic [3:0]                ofs_held;
  logic                      addr_read;
  logic [3:0]                hdr_count;
  logic [3:0]                file_cnt;
  logic [`SCL_SEG_W-1:0]     pick_seg;
  assign file_cnt = CFG_RD_DATA[`SCL_HDR_CNT_MSB:`SCL_HDR_CNT_LSB];
  // A zero count picks segment 0; a select code at or past the count falls back to the last stored file
  assign pick_seg = (file_cnt == 4'h0) ? 5'h00
                  : (sel_held >= file_cnt) ? {1'b0, file_cnt - 4'h1} : {1'b0, sel_held};

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST || !por_released)
    begin
      state     <= SCL_WAIT_POR;
      word_idx  <= '0;
      load_seg  <= '0;
      sel_held  <= '0;
      ofs_held  <= '0;
      addr_read <= 1'b0;
      hdr_count <= '0;
    end
    else
    begin
      case (state)
        SCL_WAIT_POR:
          state <= SCL_SAMPLE;
        SCL_SAMPLE:
        begin
          // Out-of-table select code clamps to the highest select, SCL_SEL_MAX
          sel_held  <= (sel_code > `SCL_SEL_MAX) ? `SCL_SEL_MAX : sel_code;
          ofs_held  <= ofs_code;
          addr_read <= 1'b1;
          state     <= SCL_HDR_ADDR;
        end
        SCL_HDR_ADDR:
          state <= SCL_HDR_DATA;
        SCL_HDR_DATA:
        begin
          hdr_count <= file_cnt;
          load_seg  <= pick_seg;
          word_idx <= '0;
          state    <= SCL_SEG_ADDR;
        end
        SCL_SEG_ADDR:
          state <= SCL_SEG_DATA;
        SCL_SEG_DATA:
        begin
          word_idx <= word_idx + 2'h1;
          if (word_idx == `SCL_WORD_LAST)
            state <= SCL_LOADED;
          else
            state <= SCL_SEG_ADDR;
        end
        SCL_LOADED:
          state <= SCL_LOADED;
        default:
          state <= SCL_WAIT_POR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Store read address
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      CFG_RD_ADDR <= '0;
    else if (state == SCL_SAMPLE)
      CFG_RD_ADDR <= {`SCL_HDR_SEG, `SCL_HDR_WORD};
    else if (state == SCL_HDR_DATA)
      CFG_RD_ADDR <= {pick_seg, 2'h0};
    else if (state == SCL_SEG_DATA)
      CFG_RD_ADDR <= {load_seg, word_idx + 2'h1};
  end

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  logic       loaded;
  logic       host_ok;
  logic [6:0] i2c_base;
  logic [6:0] pmb_base;
  logic [7:0] ctrl;
  logic [4:0] sw_en;
  logic [6:0] load_addr;

  assign loaded    = (state == SCL_LOADED);
  assign host_ok   = loaded && HOST_WR_EN;
  assign load_addr = {load_seg, word_idx};

  // Store reads land one cycle after the address, so the word index still matches
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      i2c_base <= `SCL_I2C_RESET;
      pmb_base <= `SCL_PMB_RESET;
      ctrl     <= `SCL_CTRL_RESET;
      sw_en    <= `SCL_SWEN_RESET;
    end
    else if (state == SCL_SEG_DATA && CFG_RD_ADDR == load_addr)
    begin
      case (word_idx)
        `SCL_WORD_I2C:  i2c_base <= CFG_RD_DATA[6:0];
        `SCL_WORD_PMB:  pmb_base <= CFG_RD_DATA[6:0];
        `SCL_WORD_CTRL: ctrl     <= {hdr_count, CFG_RD_DATA[3:0]};
        `SCL_WORD_SWEN: sw_en    <= CFG_RD_DATA[4:0];
        default:        sw_en    <= sw_en;
      endcase
    end
    else if (host_ok)
    begin
      case (HOST_SEL)
        `SCL_REG_I2C:  i2c_base <= HOST_WR_DATA[6:0];
        `SCL_REG_PMB:  pmb_base <= HOST_WR_DATA[6:0];
        `SCL_REG_CTRL: ctrl     <= HOST_WR_DATA;
        `SCL_REG_SWEN: sw_en    <= HOST_WR_DATA[4:0];
        default:       ctrl     <= ctrl;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Host read-back
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      HOST_RD_DATA <= '0;
    else
    begin
      case (HOST_SEL)
        `SCL_REG_I2C:    HOST_RD_DATA <= {1'b0, i2c_base};
        `SCL_REG_PMB:    HOST_RD_DATA <= {1'b0, pmb_base};
        `SCL_REG_CTRL:   HOST_RD_DATA <= ctrl;
        `SCL_REG_SWEN:   HOST_RD_DATA <= {3'h0, sw_en};
        `SCL_REG_STATUS: HOST_RD_DATA <= {5'h00, addr_read, loaded, por_released};
        `SCL_REG_SEL:    HOST_RD_DATA <= {load_seg[3:0], ofs_held};
        default:         HOST_RD_DATA <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus addresses
  // ----------------------------------------------------------------
  logic [3:0] ofs_add;

  assign ofs_add = ctrl[`SCL_CTRL_EXT_OFS] ? ofs_held : 4'h0;

  // Offset wraps within seven bits; no carry into a reserved range
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      I2C_ADDR   <= `SCL_I2C_RESET;
      PMB_ADDR   <= `SCL_PMB_RESET;
      I2C_ENABLE <= 1'b0;
      PMB_ENABLE <= 1'b0;
    end
    else
    begin
      I2C_ADDR   <= i2c_base + {3'h0, ofs_add};
      PMB_ADDR   <= pmb_base + {3'h0, ofs_add};
      I2C_ENABLE <= loaded && (i2c_base != 7'h00);
      PMB_ENABLE <= loaded && (pmb_base != 7'h00);
    end
  end

  // ----------------------------------------------------------------
  // Rail conversion enables
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      RAIL_CONV_EN <= '0;
    else if (ctrl[`SCL_CTRL_SW_OVR] && loaded)
      RAIL_CONV_EN <= sw_en;
    else
      RAIL_CONV_EN <= en_pin & uv_ok & {`SCL_RAIL_COUNT{loaded && addr_read}};
  end

  // ----------------------------------------------------------------
  // Store programming, one write per unused segment; any write marks the whole segment used
  // ----------------------------------------------------------------
  logic prog_bad;

  assign prog_bad = (PROG_SEG >= `SCL_SEG_COUNT) || CFG_SEG_WRITTEN[PROG_SEG];

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      CFG_WR_EN    <= 1'b0;
      CFG_WR_ADDR  <= '0;
      CFG_WR_DATA  <= '0;
      PROG_REFUSED <= 1'b0;
    end
    else
    begin
      CFG_WR_EN    <= PROG_REQ && loaded && !prog_bad;
      CFG_WR_ADDR  <= {PROG_SEG, PROG_WORD};
      CFG_WR_DATA  <= PROG_DATA;
      PROG_REFUSED <= PROG_REQ && (!loaded || prog_bad);
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      POR_DONE  <= 1'b0;
      LOAD_DONE <= 1'b0;
    end
    else
    begin
      POR_DONE  <= por_released;
      LOAD_DONE <= loaded;
    end
  end

endmodule : scl_loader

`default_nettype wire

// file: scl_loader_assertions.sv
// Concurrent checks on the loader's top-level ports.
// Assumes one clock domain and binding onto scl_loader.
`timescale 1ns/1ns
`default_nettype none
module scl_loader_assertions
(
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic [6:0]  CFG_RD_ADDR,
  input wire logic [19:0] CFG_SEG_WRITTEN,
  input wire logic        PROG_REQ,
  input wire logic [4:0]  PROG_SEG,
  input wire logic [1:0]  PROG_WORD,
  input wire logic [7:0]  PROG_DATA,
  input wire logic        CFG_WR_EN,
  input wire logic [6:0]  CFG_WR_ADDR,
  input wire logic [7:0]  CFG_WR_DATA,
  input wire logic        PROG_REFUSED,
  input wire logic        HOST_WR_EN,
  input wire logic [2:0]  HOST_SEL,
  input wire logic [7:0]  HOST_WR_DATA,
  input wire logic        POR_DONE,
  input wire logic        LOAD_DONE,
  input wire logic [6:0]  I2C_ADDR,
  input wire logic        I2C_ENABLE,
  input wire logic [6:0]  PMB_ADDR,
  input wire logic [4:0]  RAIL_CONV_EN
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  sequence s_hdr_fetch;
    ##[0:4] (CFG_RD_ADDR == 7'h02);
  endsequence
  sequence s_load_end;
    $rose(LOAD_DONE);
  endsequence
  AST_RESET_ADDR: assert property ($fell(SYS_RST) |-> I2C_ADDR == 7'h10 && PMB_ADDR == 7'h40)
    else $error("addresses not at reset values");
  AST_LOAD_SEQ: assert property ($rose(POR_DONE) |-> s_hdr_fetch ##[1:20] s_load_end)
    else $error("load did not fetch header then finish");
  AST_LOAD_POR: assert property ($rose(LOAD_DONE) |-> POR_DONE && $past(POR_DONE))
    else $error("load finished without power-on release");
  AST_RAIL_GATE: assert property (!LOAD_DONE [*3] |-> RAIL_CONV_EN == 5'h00)
    else $error("rail enabled before load");
  AST_I2C_LOADED: assert property (I2C_ENABLE |-> LOAD_DONE || $past(LOAD_DONE))
    else $error("bus enabled before load");
  AST_ZERO_OFF: assert property (HOST_WR_EN && LOAD_DONE && HOST_SEL == 3'h0 |->
    ##2 I2C_ENABLE == (($past(HOST_WR_DATA, 2) & 8'h7F) != 8'h00))
    else $error("zero base did not disable");
  AST_PROG_ONE: assert property (PROG_REQ |=> CFG_WR_EN ^ PROG_REFUSED)
    else $error("program request not answered once");
  AST_PROG_REFUSE: assert property (PROG_REQ && (PROG_SEG >= 5'h14 || CFG_SEG_WRITTEN[PROG_SEG] || !LOAD_DONE)
    |=> PROG_REFUSED && !CFG_WR_EN)
    else $error("used or absent segment written");
  AST_PROG_WRITE: assert property (PROG_REQ && LOAD_DONE && PROG_SEG < 5'h14 && !CFG_SEG_WRITTEN[PROG_SEG]
    |=> CFG_WR_EN && CFG_WR_ADDR == {$past(PROG_SEG), $past(PROG_WORD)} && CFG_WR_DATA == $past(PROG_DATA))
    else $error("store write wrong");
endmodule : scl_loader_assertions
bind scl_loader scl_loader_assertions scl_loader_assertions_inst
(
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CFG_RD_ADDR(CFG_RD_ADDR), .CFG_SEG_WRITTEN(CFG_SEG_WRITTEN),
  .PROG_REQ(PROG_REQ), .PROG_SEG(PROG_SEG), .PROG_WORD(PROG_WORD), .PROG_DATA(PROG_DATA),
  .CFG_WR_EN(CFG_WR_EN), .CFG_WR_ADDR(CFG_WR_ADDR), .CFG_WR_DATA(CFG_WR_DATA), .PROG_REFUSED(PROG_REFUSED),
  .HOST_WR_EN(HOST_WR_EN), .HOST_SEL(HOST_SEL), .HOST_WR_DATA(HOST_WR_DATA), .POR_DONE(POR_DONE),
  .LOAD_DONE(LOAD_DONE), .I2C_ADDR(I2C_ADDR), .I2C_ENABLE(I2C_ENABLE), .PMB_ADDR(PMB_ADDR),
  .RAIL_CONV_EN(RAIL_CONV_EN)
);
`default_nettype wire

// file: scl_loader_tb.sv
// Self-checking bench of the loader with the store model.
// Assumes the host side is driven directly by these tasks.
`timescale 1ns/1ns
`default_nettype none
module scl_loader_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        CORE_CLK = 1'b0, SYS_RST = 1'b1, SUPPLY_OK = 1'b0, CORE_RAIL_OK = 1'b0, OSC_STABLE = 1'b0;
  logic [3:0]  SEG_SEL_CODE = 4'h0, ADDR_OFS_CODE = 4'h0;
  logic [4:0]  RAIL_EN_PIN = 5'h16, VIN_UV_OK = 5'h1C, RAIL_CONV_EN, PROG_SEG = 5'h00;
  logic [6:0]  CFG_RD_ADDR, CFG_WR_ADDR, I2C_ADDR, PMB_ADDR;
  logic [7:0]  CFG_RD_DATA, CFG_WR_DATA, PROG_DATA = 8'h00, HOST_WR_DATA = 8'h00, HOST_RD_DATA;
  logic [19:0] CFG_SEG_WRITTEN;
  logic        PROG_REQ = 1'b0, HOST_WR_EN = 1'b0, CFG_WR_EN, PROG_REFUSED;
  logic        POR_DONE, LOAD_DONE, I2C_ENABLE, PMB_ENABLE;
  logic [1:0]  PROG_WORD = 2'h0;
  logic [2:0]  HOST_SEL = 3'h0;
  logic [34:0] rows [5];
  int          n_mismatch = 0, checked = 0, cyc = 0;
  scl_loader scl_loader_inst
  (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .SUPPLY_OK(SUPPLY_OK), .CORE_RAIL_OK(CORE_RAIL_OK),
    .OSC_STABLE(OSC_STABLE), .SEG_SEL_CODE(SEG_SEL_CODE), .ADDR_OFS_CODE(ADDR_OFS_CODE),
    .RAIL_EN_PIN(RAIL_EN_PIN), .VIN_UV_OK(VIN_UV_OK), .CFG_RD_ADDR(CFG_RD_ADDR), .CFG_RD_DATA(CFG_RD_DATA),
    .CFG_SEG_WRITTEN(CFG_SEG_WRITTEN), .PROG_REQ(PROG_REQ), .PROG_SEG(PROG_SEG), .PROG_WORD(PROG_WORD),
    .PROG_DATA(PROG_DATA), .CFG_WR_EN(CFG_WR_EN), .CFG_WR_ADDR(CFG_WR_ADDR), .CFG_WR_DATA(CFG_WR_DATA),
    .PROG_REFUSED(PROG_REFUSED), .HOST_WR_EN(HOST_WR_EN), .HOST_SEL(HOST_SEL), .HOST_WR_DATA(HOST_WR_DATA),
    .HOST_RD_DATA(HOST_RD_DATA), .POR_DONE(POR_DONE), .LOAD_DONE(LOAD_DONE), .I2C_ADDR(I2C_ADDR),
    .I2C_ENABLE(I2C_ENABLE), .PMB_ADDR(PMB_ADDR), .PMB_ENABLE(PMB_ENABLE), .RAIL_CONV_EN(RAIL_CONV_EN)
  );
  scl_store_model scl_store_model_inst
  (
    .CORE_CLK(CORE_CLK), .CFG_RD_ADDR(CFG_RD_ADDR), .CFG_RD_DATA(CFG_RD_DATA), .CFG_WR_EN(CFG_WR_EN),
    .CFG_WR_ADDR(CFG_WR_ADDR), .CFG_WR_DATA(CFG_WR_DATA), .CFG_SEG_WRITTEN(CFG_SEG_WRITTEN)
  );
  always #4 CORE_CLK = ~CORE_CLK;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_load();
    for (int i = 0; i < 100 && LOAD_DONE !== 1'b1; i++)
      @(negedge CORE_CLK);
    chk({7'h0, LOAD_DONE}, 8'h01);
    repeat (3) @(negedge CORE_CLK);
  endtask : wait_load
  task automatic boot(input logic [3:0] sel, input logic [3:0] ofs);
    SYS_RST = 1'b1;
    {SUPPLY_OK, CORE_RAIL_OK, OSC_STABLE} = 3'h0;
    SEG_SEL_CODE = sel;
    ADDR_OFS_CODE = ofs;
    repeat (4) @(negedge CORE_CLK);
    chk({1'b0, I2C_ADDR}, 8'h10);
    chk({1'b0, PMB_ADDR}, 8'h40);
    SYS_RST = 1'b0;
    {SUPPLY_OK, CORE_RAIL_OK, OSC_STABLE} = 3'h7;
    wait_load();
  endtask : boot
  task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
    HOST_SEL = sel;
    @(negedge CORE_CLK);
    chk(HOST_RD_DATA, exp);
  endtask : rd
  // Two falling edges: the address follows the base one edge late
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    {HOST_WR_EN, HOST_SEL, HOST_WR_DATA} = {1'b1, sel, d};
    @(negedge CORE_CLK);
    HOST_WR_EN = 1'b0;
    @(negedge CORE_CLK);
  endtask : wr
  task automatic pg(input logic [4:0] seg, input logic [1:0] word, input logic [7:0] d, input logic ok);
    {PROG_REQ, PROG_SEG, PROG_WORD, PROG_DATA} = {1'b1, seg, word, d};
    @(negedge CORE_CLK);
    chk({6'h0, CFG_WR_EN, PROG_REFUSED}, {6'h0, ok, ~ok});
    if (ok)
      chk({1'b0, CFG_WR_ADDR} ^ CFG_WR_DATA, {1'b0, seg, word} ^ d);
    PROG_REQ = 1'b0;
    @(negedge CORE_CLK);
  endtask : pg
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial
  begin
    // Row: select, offset, i2c, pmbus, rails, readback of select register
    rows = '{{4'h0, 4'h3, 7'h20, 7'h50, 5'h14, 8'h03}, {4'h1, 4'h5, 7'h26, 7'h56, 5'h14, 8'h15},
             {4'h2, 4'h0, 7'h22, 7'h52, 5'h0B, 8'h20}, {4'h9, 4'h1, 7'h22, 7'h52, 5'h0B, 8'h21},
             {4'hF, 4'hF, 7'h22, 7'h52, 5'h0B, 8'h2F}};
    for (int r = 0; r < 5; r++)
    begin
      boot(rows[r][34:31], rows[r][30:27]);
      chk({1'b0, I2C_ADDR}, {1'b0, rows[r][26:20]});
      chk({1'b0, PMB_ADDR}, {1'b0, rows[r][19:13]});
      chk({3'h0, RAIL_CONV_EN}, {3'h0, rows[r][12:8]});
      chk({6'h0, I2C_ENABLE, PMB_ENABLE}, 8'h03);
      rd(3'h5, rows[r][7:0]);
    end
    {SEG_SEL_CODE, ADDR_OFS_CODE} = 8'h00;
    repeat (4) @(negedge CORE_CLK);
    rd(3'h5, 8'h2F);
    rd(3'h4, 8'h07);
    rd(3'h3, 8'h0B);
    RAIL_EN_PIN = 5'h00;
    wr(3'h0, 8'h00);
    chk({7'h0, I2C_ENABLE}, 8'h00);
    wr(3'h1, 8'h33);
    chk({1'b0, PMB_ADDR}, 8'h33);
    wr(3'h6, 8'hFF);
    rd(3'h1, 8'h33);
    rd(3'h2, 8'h32);
    pg(5'h03, 2'h1, 8'h77, 1'b1);
    pg(5'h03, 2'h2, 8'h11, 1'b0);
    pg(5'h00, 2'h0, 8'h11, 1'b0);
    pg(5'h14, 2'h0, 8'h11, 1'b0);
    SUPPLY_OK = 1'b0;
    repeat (6) @(negedge CORE_CLK);
    chk({5'h0, POR_DONE, LOAD_DONE, |RAIL_CONV_EN}, 8'h00);
    SUPPLY_OK = 1'b1;
    wait_load();
    chk({1'b0, I2C_ADDR}, 8'h20);
    wrap_up();
  end
endmodule : scl_loader_tb
`default_nettype wire

// file: scl_pkg.sv
// Types of the startup configuration loader.
// Assumes scl_consts.svh sits beside it.
`include "scl_consts.svh"

package scl_pkg;

  // ----------------------------------------------------------------
  // Load sequence states
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SCL_WAIT_POR,
    SCL_SAMPLE,
    SCL_HDR_ADDR,
    SCL_HDR_DATA,
    SCL_SEG_ADDR,
    SCL_SEG_DATA,
    SCL_LOADED
  } scl_state_type;

endpackage : scl_pkg

// file: scl_store_model.sv
// Behavioural config store: 20 segments, three files programmed.
// Assumes one read cycle of latency, as the loader expects.
`timescale 1ns/1ns
`default_nettype none
module scl_store_model
(
  input  wire logic        CORE_CLK,
  input  wire logic [6:0]  CFG_RD_ADDR,
  output var  logic [7:0]  CFG_RD_DATA,
  input  wire logic        CFG_WR_EN,
  input  wire logic [6:0]  CFG_WR_ADDR,
  input  wire logic [7:0]  CFG_WR_DATA,
  output var  logic [19:0] CFG_SEG_WRITTEN
);
  // ----------------------------------------------------------------
  // Contents
  // ----------------------------------------------------------------
  logic [7:0] mem [128];
  initial
  begin
    for (int a = 0; a < 128; a++)
      mem[a] = 8'hA5;
    for (int k = 0; k < 3; k++)
    begin
      mem[4*k] = 8'h20 | 8'(k);
      mem[4*k+1] = 8'h50 | 8'(k);
      mem[4*k+2] = 8'(k);
      mem[4*k+3] = 8'h0B;
    end
    mem[2] = 8'h30;
    CFG_SEG_WRITTEN = 20'h0_0007;
  end
  // Burned bits only ever set; a real store cannot clear them
  always @(posedge CORE_CLK)
  begin
    CFG_RD_DATA <= mem[CFG_RD_ADDR];
    if (CFG_WR_EN)
    begin
      mem[CFG_WR_ADDR] <= CFG_WR_DATA;
      CFG_SEG_WRITTEN[CFG_WR_ADDR[6:2]] <= 1'b1;
    end
  end
endmodule : scl_store_model
`default_nettype wire

// file: scl_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes a single destination clock; first stage feeds only the second.
`timescale 1ns/1ns
`default_nettype none

module scl_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage_one <= '0;
      sync_out  <= '0;
    end
    else
    begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule : scl_sync

`default_nettype wire
